// ### inc/scp_map.vh
/*
  Register map of the core system control and protection bank.
  Offsets are byte addresses on the AXI4-Lite slave; included by design files.
*/
`ifndef SCP_MAP_VH
`define SCP_MAP_VH

// Register byte offsets (low 16 bits of address)
`define SCP_OFF_CFG 16'hED14
`define SCP_OFF_SVC_PRI 16'hED1C
`define SCP_OFF_TICK_PRI 16'hED20
`define SCP_OFF_PEND 16'hED24
`define SCP_OFF_PU_INFO 16'hED90
`define SCP_OFF_PU_CTRL 16'hED94

// Configuration register fields
`define SCP_CFG_STKALN_BIT 9
`define SCP_CFG_TRAP_BIT 3

// Priority field positions
`define SCP_SVC_PRI_HI 31
`define SCP_SVC_PRI_LO 30
`define SCP_TICK_PRI_HI 31
`define SCP_TICK_PRI_LO 30
`define SCP_PEND_PRI_HI 23
`define SCP_PEND_PRI_LO 22

// Handler state register
`define SCP_SVC_PEND_BIT 15

// Protection unit info fields
`define SCP_INFO_IREG_HI 23
`define SCP_INFO_IREG_LO 16
`define SCP_INFO_DREG_HI 15
`define SCP_INFO_DREG_LO 8
`define SCP_INFO_SEP_BIT 0
`define SCP_REGION_COUNT 8'h08
`define SCP_INSTR_REGION_COUNT 8'h00

// Protection unit control fields
`define SCP_CTRL_EN_BIT 0
`define SCP_CTRL_HF_BIT 1
`define SCP_CTRL_BG_BIT 2

// Reset values
`define SCP_RST_PRI 2'h0
`define SCP_RST_CTRL 3'h0

// Status word bit recording stack adjustment
`define SCP_PSW_ALIGN_BIT 9

// AXI responses
`define SCP_RESP_OKAY 2'h0
`define SCP_RESP_SLVERR 2'h2

`endif

// ### rtl/scp_field.v
/*
  Small writable register field with reset value.
  Assumes a single clock and an asynchronous active-low reset.
*/
`timescale 1ns/10ps

module scp_field #(
  parameter WIDTH = 2,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
  input wire clk_sys,
  input wire reset_n,
  input wire wr_en,
  input wire [WIDTH-1:0] wr_data,
  output reg [WIDTH-1:0] value
);

  // Load on write strobe
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      value <= RESET_VALUE;
    end else if (wr_en) begin
      value <= wr_data;
    end
  end

endmodule // scp_field

// ### rtl/scp_prot_check.v
/*
  Access permission decision of the protection unit from control bits.
  Assumes region match and fault-handler context come from the core.
*/
`timescale 1ns/10ps

module scp_prot_check (
  input wire unit_en,
  input wire background_en,
  input wire fault_protect_en,
  input wire acc_valid,
  input wire acc_privileged,
  input wire acc_misaligned,
  input wire region_hit,
  input wire region_permit,
  input wire in_fault_handler,
  output reg acc_fault,
  output reg acc_default_map
);

  // Decide fault and map selection
  always @* begin
    acc_fault = 1'b0;
    acc_default_map = 1'b0;
    if (!acc_valid) begin
      acc_fault = 1'b0;
    end else if (acc_misaligned) begin
      acc_fault = 1'b1;
    end else if (!unit_en) begin
      acc_default_map = 1'b1;
    end else if (in_fault_handler && !fault_protect_en) begin
      acc_default_map = 1'b1;
    end else if (region_hit) begin
      acc_fault = !region_permit;
    end else if (background_en && acc_privileged) begin
      acc_default_map = 1'b1;
    end else begin
      acc_fault = 1'b1;
    end
  end

endmodule // scp_prot_check

// ### rtl/scp_regs.v
/*
  System control and protection register bank with AXI4-Lite slave,
  stack alignment bookkeeping and protection decision.
  Assumes one 20 MHz clock clk_sys, asynchronous active-low reset_n,
  and core-side signals synchronous to clk_sys.
*/
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/10ps
`include "scp_map.vh"

module scp_regs (
  input wire clk_sys,
  input wire reset_n,
  // AXI4-Lite write address
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Core exception events
  input wire svc_raise,
  input wire svc_taken,
  input wire exc_entry,
  input wire exc_return,
  input wire [31:0] sp_current,
  input wire [31:0] stacked_psw,
  output reg [31:0] sp_entry,
  output reg [31:0] psw_to_stack,
  output reg [31:0] sp_restored,
  // Core data access check
  input wire acc_valid,
  input wire acc_privileged,
  input wire [1:0] acc_size,
  input wire [1:0] acc_addr_low,
  input wire region_hit,
  input wire region_permit,
  input wire in_fault_handler,
  output wire acc_fault,
  output wire acc_default_map,
  // Field values to the exception logic
  output wire [1:0] supervisor_call_prio_field,
  output wire [1:0] tick_handler_prio_field,
  output wire [1:0] pended_service_prio_field,
  output wire supervisor_call_pending,
  output wire protection_unit_en
);

  // Write channel holding registers
  reg aw_held; // Write address captured
  reg [15:0] aw_addr; // Captured write address
  reg w_held; // Write data captured
  reg [31:0] w_data; // Captured write data
  reg [3:0] w_strb; // Captured byte strobes
  wire wr_go; // Both halves present, response free
  wire [31:0] wr_word; // Write data as seen by registers

  // Decoded write strobes
  wire wr_svc_pri;
  wire wr_tick_pri;
  wire wr_pend;
  wire wr_ctrl;
  wire wr_known;

  // Register state
  reg pend_state; // Supervisor call pending flag
  reg [2:0] unit_ctrl; // Protection control bits
  reg [31:0] next_rdata; // Read mux output
  reg next_rok; // Read address mapped

  // Access alignment
  wire misaligned;

  // Accept each write half while not already held
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign wr_go = aw_held && w_held && !s_axi_bvalid;
  // Only the top byte lanes matter for priority; full captured word used whatever the strobes
  assign wr_word = w_data;

  // Capture write address and data independently
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      aw_held <= 1'b0;
      aw_addr <= 16'h0000;
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr[15:0];
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // Address decode for writes, byte lanes gate each field
  assign wr_svc_pri = wr_go && (aw_addr == `SCP_OFF_SVC_PRI) && w_strb[3];
  assign wr_tick_pri = wr_go && (aw_addr == `SCP_OFF_TICK_PRI) && w_strb[3];
  assign wr_pend = wr_go && (aw_addr == `SCP_OFF_PEND) && w_strb[1];
  assign wr_ctrl = wr_go && (aw_addr == `SCP_OFF_PU_CTRL) && w_strb[0];
  // Read-only registers accepted with OKAY and no change
  assign wr_known = (aw_addr == `SCP_OFF_CFG) || (aw_addr == `SCP_OFF_SVC_PRI) ||
    (aw_addr == `SCP_OFF_TICK_PRI) || (aw_addr == `SCP_OFF_PEND) ||
    (aw_addr == `SCP_OFF_PU_INFO) || (aw_addr == `SCP_OFF_PU_CTRL);

  // Write response
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SCP_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_known ? `SCP_RESP_OKAY : `SCP_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Supervisor call priority field
  scp_field #(.WIDTH(2), .RESET_VALUE(`SCP_RST_PRI)) u_svc_pri (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wr_en(wr_svc_pri),
    .wr_data(wr_word[`SCP_SVC_PRI_HI:`SCP_SVC_PRI_LO]),
    .value(supervisor_call_prio_field)
  );

  // Tick handler priority field
  scp_field #(.WIDTH(2), .RESET_VALUE(`SCP_RST_PRI)) u_tick_pri (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wr_en(wr_tick_pri),
    .wr_data(wr_word[`SCP_TICK_PRI_HI:`SCP_TICK_PRI_LO]),
    .value(tick_handler_prio_field)
  );

  // Pended service priority field, upper byte lane 2
  scp_field #(.WIDTH(2), .RESET_VALUE(`SCP_RST_PRI)) u_pend_pri (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wr_en(wr_go && (aw_addr == `SCP_OFF_TICK_PRI) && w_strb[2]),
    .wr_data(wr_word[`SCP_PEND_PRI_HI:`SCP_PEND_PRI_LO]),
    .value(pended_service_prio_field)
  );

  // Supervisor call pending: raise wins over software clear and over take
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pend_state <= 1'b0;
    end else if (svc_raise) begin
      pend_state <= 1'b1;
    end else if (wr_pend) begin
      pend_state <= wr_word[`SCP_SVC_PEND_BIT];
    end else if (svc_taken) begin
      pend_state <= 1'b0;
    end
  end
  assign supervisor_call_pending = pend_state;

  // Protection unit control bits
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      unit_ctrl <= `SCP_RST_CTRL;
    end else if (wr_ctrl) begin
      unit_ctrl <= wr_word[2:0];
    end
  end
  assign protection_unit_en = unit_ctrl[`SCP_CTRL_EN_BIT];

  // Read data mux, reserved bits zero
  always @* begin
    next_rdata = 32'h00000000;
    next_rok = 1'b1;
    case (s_axi_araddr[15:0])
      `SCP_OFF_CFG: begin
        next_rdata[`SCP_CFG_STKALN_BIT] = 1'b1;
        next_rdata[`SCP_CFG_TRAP_BIT] = 1'b1;
      end
      `SCP_OFF_SVC_PRI: begin
        next_rdata[`SCP_SVC_PRI_HI:`SCP_SVC_PRI_LO] = supervisor_call_prio_field;
      end
      `SCP_OFF_TICK_PRI: begin
        next_rdata[`SCP_TICK_PRI_HI:`SCP_TICK_PRI_LO] = tick_handler_prio_field;
        next_rdata[`SCP_PEND_PRI_HI:`SCP_PEND_PRI_LO] = pended_service_prio_field;
      end
      `SCP_OFF_PEND: begin
        next_rdata[`SCP_SVC_PEND_BIT] = pend_state;
      end
      `SCP_OFF_PU_INFO: begin
        next_rdata[`SCP_INFO_IREG_HI:`SCP_INFO_IREG_LO] = `SCP_INSTR_REGION_COUNT;
        next_rdata[`SCP_INFO_DREG_HI:`SCP_INFO_DREG_LO] = `SCP_REGION_COUNT;
        next_rdata[`SCP_INFO_SEP_BIT] = 1'b0;
      end
      `SCP_OFF_PU_CTRL: begin
        next_rdata[2:0] = unit_ctrl;
      end
      default: begin
        next_rok = 1'b0; // Unmapped address
      end
    endcase
  end

  // Read channel: one outstanding read
  assign s_axi_arready = !s_axi_rvalid;
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SCP_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rok ? `SCP_RESP_OKAY : `SCP_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Stack alignment on exception entry and return
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sp_entry <= 32'h00000000;
      psw_to_stack <= 32'h00000000;
      sp_restored <= 32'h00000000;
    end else begin
      if (exc_entry) begin
        // Round down to 8 bytes, remember the adjustment
        sp_entry <= {sp_current[31:3], 3'h0};
        psw_to_stack <= stacked_psw;
        psw_to_stack[`SCP_PSW_ALIGN_BIT] <= sp_current[2];
      end
      if (exc_return) begin
        // Put back the word removed on entry
        sp_restored <= {sp_current[31:3],
          stacked_psw[`SCP_PSW_ALIGN_BIT], sp_current[1:0]};
      end
    end
  end

  // Misaligned when address low bits do not fit access size
  assign misaligned = ((acc_size == 2'h1) && acc_addr_low[0]) ||
    ((acc_size == 2'h2) && (acc_addr_low != 2'h0));

  // Protection decision
  scp_prot_check u_check (
    .unit_en(unit_ctrl[`SCP_CTRL_EN_BIT]),
    .background_en(unit_ctrl[`SCP_CTRL_BG_BIT]),
    .fault_protect_en(unit_ctrl[`SCP_CTRL_HF_BIT]),
    .acc_valid(acc_valid),
    .acc_privileged(acc_privileged),
    .acc_misaligned(misaligned),
    .region_hit(region_hit),
    .region_permit(region_permit),
    .in_fault_handler(in_fault_handler),
    .acc_fault(acc_fault),
    .acc_default_map(acc_default_map)
  );

endmodule // scp_regs

// ### sim/scp_regs_chk.sv
/*
  Port assertions for the system control and protection bank.
  Bound to scp_regs; sees only its ports, one clock, async low reset.
*/
`timescale 1ns/10ps

module scp_regs_chk (
  input wire clk_sys,
  input wire reset_n,
  input wire svc_raise,
  input wire exc_entry,
  input wire exc_return,
  input wire [31:0] sp_current,
  input wire [31:0] stacked_psw,
  input wire [31:0] sp_entry,
  input wire [31:0] psw_to_stack,
  input wire [31:0] sp_restored,
  input wire acc_valid,
  input wire acc_privileged,
  input wire [1:0] acc_size,
  input wire [1:0] acc_addr_low,
  input wire region_hit,
  input wire region_permit,
  input wire in_fault_handler,
  input wire acc_fault,
  input wire acc_default_map,
  input wire supervisor_call_pending,
  input wire protection_unit_en
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Access that is not naturally aligned
  wire mis = acc_valid && ((acc_size == 2'h2 && acc_addr_low != 2'h0) ||
    (acc_size == 2'h1 && acc_addr_low[0]));
  // Aligned access under test
  wire aok = acc_valid && !mis;
  // Entry event followed by its result cycle
  sequence entry_s;
    exc_entry ##1 1'b1;
  endsequence
  stk_round_a: assert property (entry_s |-> sp_entry == {$past(sp_current[31:3]), 3'h0})
    else $error("entry stack pointer not rounded to 8");
  psw_mark_a: assert property (entry_s |-> psw_to_stack[9] == $past(sp_current[2]))
    else $error("stacked status bit 9 wrong");
  sp_restore_a: assert property (exc_return |=> sp_restored[2] == $past(stacked_psw[9])
    && sp_restored[1:0] == $past(sp_current[1:0])) else $error("restored pointer wrong");
  misalign_trap_a: assert property (mis |-> acc_fault)
    else $error("misaligned access not faulted");
  pend_raise_a: assert property (svc_raise |=> supervisor_call_pending)
    else $error("raise did not set pending");
  unit_off_a: assert property (aok && !protection_unit_en |-> !acc_fault && acc_default_map)
    else $error("disabled unit did not use default map");
  region_rank_a: assert property (aok && protection_unit_en && region_hit && region_permit
    && !in_fault_handler |-> !acc_fault && !acc_default_map) else $error("region hit lost");
  unpriv_miss_a: assert property (aok && protection_unit_en && !region_hit && !acc_privileged
    && !in_fault_handler |-> acc_fault) else $error("unprivileged miss not faulted");
endmodule // scp_regs_chk

bind scp_regs scp_regs_chk u_chk (.*);

// ### sim/tb_top.sv
/*
  Self-checking bench for scp_regs: AXI4-Lite register tasks, access checks
  and exception events. Assumes the checker is bound from its own file.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module tb_top;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [31:0] sp_current = '0, stacked_psw = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic svc_raise = 0, svc_taken = 0, exc_entry = 0, exc_return = 0;
  logic acc_valid = 0, acc_privileged = 0, region_hit = 0, region_permit = 0, in_fault_handler = 0;
  logic [1:0] acc_size = '0, acc_addr_low = '0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [1:0] supervisor_call_prio_field, tick_handler_prio_field, pended_service_prio_field;
  wire [31:0] s_axi_rdata, sp_entry, psw_to_stack, sp_restored;
  wire acc_fault, acc_default_map, supervisor_call_pending, protection_unit_en;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;

  scp_regs dut (.*);

  // 20 MHz clock
  always #25 clk_sys = ~clk_sys;

  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      end_of_test;
    end
  end

  // Counts and verdict
  task automatic end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // One write; handshakes sampled mid-cycle, released after the taking edge
  task automatic wr(input [15:0] a, input [31:0] d, input [3:0] s, input [1:0] r);
    logic ta, tw, b;
    logic [1:0] rsp;
    b = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr <= {16'h0000, a};
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b) begin
      @(negedge clk_sys);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge clk_sys);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
    end
    `CHK(rsp, r)
  endtask

  // One read; data compared only when an OKAY answer is expected
  task automatic rd(input [15:0] a, input [31:0] e, input [1:0] r);
    logic ta, b;
    logic [1:0] rsp;
    logic [31:0] d;
    b = 1'b0;
    @(posedge clk_sys);
    s_axi_araddr <= {16'h0000, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!b) begin
      @(negedge clk_sys);
      ta = s_axi_arvalid && s_axi_arready;
      b = s_axi_rvalid;
      d = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge clk_sys);
      if (ta) s_axi_arvalid <= 1'b0;
      if (b) s_axi_rready <= 1'b0;
    end
    `CHK(rsp, r)
    if (r == 2'h0) `CHK(d, e)
  endtask

  // Access check: v = priv, hit, permit, in handler, size, low address
  task automatic ac(input [7:0] v, input [1:0] m, input [1:0] e);
    @(posedge clk_sys);
    {acc_privileged, region_hit, region_permit, in_fault_handler, acc_size, acc_addr_low} <= v;
    acc_valid <= 1'b1;
    @(negedge clk_sys);
    `CHK({acc_fault, acc_default_map} & m, e)
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(16'hED14, 32'h00000208, 2'h0);
    rd(16'hED90, 32'h00000800, 2'h0);
    rd(16'hED20, 32'h00000000, 2'h0);
    wr(16'hED14, 32'hFFFFFFFF, 4'hF, 2'h0);
    wr(16'hED90, 32'hFFFFFFFF, 4'hF, 2'h0);
    rd(16'hED14, 32'h00000208, 2'h0);
    rd(16'hED90, 32'h00000800, 2'h0);
    wr(16'hED1C, 32'hFFFFFFFF, 4'hF, 2'h0);
    rd(16'hED1C, 32'hC0000000, 2'h0);
    wr(16'hED20, 32'hFFFFFFFF, 4'hF, 2'h0);
    rd(16'hED20, 32'hC0C00000, 2'h0);
    wr(16'hED20, 32'h00000000, 4'h4, 2'h0);
    rd(16'hED20, 32'hC0000000, 2'h0);
    `CHK(supervisor_call_prio_field, 2'h3)
    `CHK(tick_handler_prio_field, 2'h3)
    `CHK(pended_service_prio_field, 2'h0)
    wr(16'hED24, 32'hFFFFFFFF, 4'hF, 2'h0);
    rd(16'hED24, 32'h00008000, 2'h0);
    wr(16'hED24, 32'h00000000, 4'hF, 2'h0);
    rd(16'hED24, 32'h00000000, 2'h0);
    @(posedge clk_sys);
    svc_raise <= 1'b1;
    @(posedge clk_sys);
    svc_raise <= 1'b0;
    rd(16'hED24, 32'h00008000, 2'h0);
    `CHK(supervisor_call_pending, 1'b1)
    @(posedge clk_sys);
    svc_taken <= 1'b1;
    @(posedge clk_sys);
    svc_taken <= 1'b0;
    rd(16'hED24, 32'h00000000, 2'h0);
    `CHK(supervisor_call_pending, 1'b0)
    // Unmapped place inside the bank
    rd(16'hED18, 32'h00000000, 2'h2);
    wr(16'hED28, 32'hFFFFFFFF, 4'hF, 2'h2);
    wr(16'hED94, 32'hFFFFFFFF, 4'hF, 2'h0);
    rd(16'hED94, 32'h00000007, 2'h0);
    wr(16'hED94, 32'h00000004, 4'hF, 2'h0);
    ac(8'b0000_1000, 2'h3, 2'h1);
    ac(8'b1000_1010, 2'h2, 2'h2);
    ac(8'b1000_0101, 2'h2, 2'h2);
    wr(16'hED94, 32'h00000001, 4'hF, 2'h0);
    `CHK(protection_unit_en, 1'b1)
    ac(8'b1000_1000, 2'h3, 2'h2);
    ac(8'b1001_1000, 2'h3, 2'h1);
    wr(16'hED94, 32'h00000005, 4'hF, 2'h0);
    ac(8'b1000_1000, 2'h3, 2'h1);
    ac(8'b0000_1000, 2'h3, 2'h2);
    ac(8'b1110_1000, 2'h3, 2'h0);
    wr(16'hED94, 32'h00000003, 4'hF, 2'h0);
    ac(8'b1001_1000, 2'h3, 2'h2);
    // Exception entry then return
    @(posedge clk_sys);
    sp_current <= 32'h20000FFC;
    stacked_psw <= 32'h01000000;
    exc_entry <= 1'b1;
    @(posedge clk_sys);
    exc_entry <= 1'b0;
    @(negedge clk_sys);
    `CHK(sp_entry, 32'h20000FF8)
    `CHK(psw_to_stack, 32'h01000200)
    @(posedge clk_sys);
    sp_current <= 32'h20000FF8;
    stacked_psw <= 32'h01000200;
    exc_return <= 1'b1;
    @(posedge clk_sys);
    exc_return <= 1'b0;
    @(negedge clk_sys);
    `CHK(sp_restored, 32'h20000FFC)
    end_of_test;
  end
endmodule // tb_top
